// file: common/rit_pkg.sv
// Constants, register map and timing figures for the interrupt, sync, pulse and trim block.
// Assumes a single 250 MHz system clock; the 32 kHz chain is an enable pulse derived from it.
package rit_pkg;
  // Register indices; byte address is four times the index
  localparam logic [4:0] IDX_STAT0 = 5'h00;
  localparam logic [4:0] IDX_STAT1 = 5'h01;
  localparam logic [4:0] IDX_STAT2 = 5'h02;
  localparam logic [4:0] IDX_TRIM = 5'h10;
  // Status 0 fields
  localparam int S0_TUNE = 0;
  localparam int S0_PULSE_EN = 1;
  localparam int S0_ALARM_EN = 2;
  localparam int S0_TIMER_EN = 3;
  localparam int S0_LOCK = 5;
  localparam int S0_TEST1 = 7;
  // Status 1 fields
  localparam int S1_PULSE_MASK = 0;
  localparam int S1_ALARM_MASK = 1;
  localparam int S1_TIMER_MASK = 2;
  localparam int S1_PULSE_FLAG = 4;
  localparam int S1_ALARM_FLAG = 5;
  localparam int S1_TIMER_FLAG = 6;
  // Status 2 fields
  localparam int S2_PSEL_LO = 0;
  localparam int S2_INIT = 4;
  localparam int S2_SYNC_LO = 5;
  localparam int S2_SYNC_50HZ = 5;
  localparam int S2_SYNC_SEC = 6;
  localparam int S2_SYNC_MIN = 7;
  // Reset values
  localparam logic [7:0] STAT0_RST = 8'h00;
  localparam logic [7:0] STAT1_RST = 8'h00;
  localparam logic [7:0] STAT2_RST = 8'h00;
  localparam logic [7:0] TRIM_RST = 8'h00;
  localparam logic [7:0] STAT0_INIT = 8'h01;
  // Clock and chain figures
  localparam int CLK_MHZ = 250;
  localparam int OSC_HZ = 32768;
  localparam int OSC_DIV_DEF = (CLK_MHZ * 1000000) / OSC_HZ;
  localparam int TICKS_10MS = OSC_HZ / 100;
  localparam int DUTY_PCT = 20;
  localparam int DUTY_TICKS = (TICKS_10MS * DUTY_PCT) / 100;
  localparam int TRIM_PERIOD = 1015808;
  localparam int SYNC_LOW_US = 200;
  localparam int SYNC_CYC_DEF = SYNC_LOW_US * CLK_MHZ;
  localparam int HUND_MAX = 99;
  localparam int TENTH_LAST = 9;
  localparam int SEC_MAX = 59;
  localparam int HUND_ROUND = 50;
  localparam int SEC_ROUND = 30;
  // Register width
  localparam int DW = 8;
endpackage : rit_pkg

// file: hdl/rit_irq_sync_pulse_trim.sv
// Interrupt, synchronisation, periodic pulse, time-set lock and digital trim of an RTC.
// Assumes an Avalon-MM master on sys_clk, pins from outside, and alarm/timer events
// as one-cycle pulses from clock logic on the same clock.
//
// Decided for this implementation: the Avalon-MM interface to the registers.
`timescale 1ns/1ps
module rit_irq_sync_pulse_trim
  import rit_pkg::*;
#(
  parameter int OSC_DIV = OSC_DIV_DEF,
  parameter int SYNC_CYC = SYNC_CYC_DEF
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // Avalon-MM slave
  input wire logic [6:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // Pins
  input wire logic power_fail_in,
  input wire logic sync_n_in,
  output logic irq_n_o,
  output logic irq_n_oe,
  // Events from clock logic
  input wire logic alarm_match_in,
  input wire logic timer_rollover_in,
  // Controls to clock logic
  output logic alarm_en_o,
  output logic timer_en_o,
  output logic xfer_write_en_o,
  output logic tick_10ms_o
);

  // True when exactly one bit is set
  function automatic logic is_one_hot(input logic [3:0] v);
    return (v != 4'h0) && ((v & (v - 4'h1)) == 4'h0);
  endfunction : is_one_hot

  logic [7:0] stat0_q, stat1_q, stat2_q, trim_q;
  logic ack_q;
  logic [31:0] rdata_q;
  logic pf_m_q, pf_q, sy_m_q, sy_q;
  logic [12:0] osc_cnt_q;
  logic osc_tick;
  logic [19:0] tper_q;
  logic [7:0] remove_q;
  logic [8:0] pre_q;
  logic tick10;
  logic [6:0] hund_q;
  logic [5:0] sec_q, min_q;
  logic [15:0] slow_q;
  logic align;
  logic freq_out_q;
  logic irq_q;
  logic req, wr_fire;
  logic [4:0] idx;
  logic [7:0] wd;
  logic init_fall;
  logic sync_on, pulse_ok, pulse_evt, tick_100, tick_sec, tick_min;
  logic alarm_set, timer_set, any_unmasked, stby_irq, irq_d;

  // Bus decode; byte address bits 1:0 are ignored
  assign req = avs_read | avs_write;
  assign idx = avs_address[6:2];
  assign wd = avs_writedata[DW-1:0];
  assign wr_fire = avs_write & ack_q;
  assign avs_waitrequest = req & ~ack_q;
  assign avs_readdata = rdata_q;

  // One wait cycle per access, then the answer
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= req & ~ack_q;
    end
  end

  // Read data captured in the wait cycle; unmapped reads give zero
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      rdata_q <= 32'h0000_0000;
    end else if (avs_read & ~ack_q) begin
      unique case (idx)
        IDX_STAT0: rdata_q <= {24'h00_0000, stat0_q};
        IDX_STAT1: rdata_q <= {24'h00_0000, stat1_q};
        IDX_STAT2: rdata_q <= {24'h00_0000, stat2_q};
        IDX_TRIM: rdata_q <= {24'h00_0000, trim_q};
        default: rdata_q <= 32'h0000_0000;
      endcase
    end
  end

  // Pin synchronisers
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      pf_m_q <= 1'b0;
      pf_q <= 1'b0;
      sy_m_q <= 1'b1;
      sy_q <= 1'b1;
    end else begin
      pf_m_q <= power_fail_in;
      pf_q <= pf_m_q;
      sy_m_q <= sync_n_in;
      sy_q <= sy_m_q;
    end
  end

  // Init bit written one then zero
  assign init_fall = wr_fire && (idx == IDX_STAT2) && stat2_q[S2_INIT] && !wd[S2_INIT];

  // Status 0: enables, lock, tuning and test bits
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      stat0_q <= STAT0_RST;
    end else if (init_fall) begin
      stat0_q <= STAT0_INIT;
    end else if (wr_fire && idx == IDX_STAT0) begin
      stat0_q <= wd;
    end
  end

  // Status 2: interval select, init bit, sync select
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      stat2_q <= STAT2_RST;
    end else if (init_fall) begin
      stat2_q <= STAT2_RST;
    end else if (wr_fire && idx == IDX_STAT2) begin
      stat2_q <= wd;
    end
  end

  // Trim register; refused while the lock is set
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      trim_q <= TRIM_RST;
    end else if (wr_fire && idx == IDX_TRIM && !stat0_q[S0_LOCK]) begin
      trim_q <= wd;
    end
  end

  // Flag sources; pulse held off in standby but its enable is kept
  assign alarm_set = alarm_match_in & stat0_q[S0_ALARM_EN];
  assign timer_set = timer_rollover_in & stat0_q[S0_TIMER_EN];
  assign pulse_ok = stat0_q[S0_PULSE_EN] && !pf_q;

  // Status 1: masks written freely, flags set by hardware, set wins over clear
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      stat1_q <= STAT1_RST;
    end else begin
      if (init_fall) begin
        stat1_q <= STAT1_RST;
      end else if (wr_fire && idx == IDX_STAT1) begin
        stat1_q <= {1'b0, wd[S1_TIMER_FLAG:S1_PULSE_FLAG], 1'b0, wd[S1_TIMER_MASK:S1_PULSE_MASK]};
      end
      if (pulse_evt) begin
        stat1_q[S1_PULSE_FLAG] <= 1'b1;
      end
      if (alarm_set) begin
        stat1_q[S1_ALARM_FLAG] <= 1'b1;
      end
      if (timer_set) begin
        stat1_q[S1_TIMER_FLAG] <= 1'b1;
      end
    end
  end

  // Oscillator enable pulse from the system clock
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      osc_cnt_q <= 13'h0000;
    end else if (osc_cnt_q == 13'(OSC_DIV - 1)) begin
      osc_cnt_q <= 13'h0000;
    end else begin
      osc_cnt_q <= osc_cnt_q + 13'h0001;
    end
  end
  assign osc_tick = (osc_cnt_q == 13'(OSC_DIV - 1));

  // Trim period and pulse removal; test bit 1 stops removal
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      tper_q <= 20'h0_0000;
      remove_q <= 8'h00;
    end else if (osc_tick) begin
      if (tper_q == 20'(TRIM_PERIOD - 1)) begin
        tper_q <= 20'h0_0000;
        remove_q <= stat0_q[S0_TEST1] ? 8'h00 : trim_q;
      end else begin
        tper_q <= tper_q + 20'h0_0001;
        if (remove_q != 8'h00) begin
          remove_q <= remove_q - 8'h01;
        end
      end
    end
  end

  // Divider to 10 ms; removed pulses do not advance it
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      pre_q <= 9'h000;
    end else if (align && stat2_q[S2_SYNC_50HZ]) begin
      pre_q <= 9'h000;
    end else if (osc_tick && remove_q == 8'h00) begin
      if (tick10) begin
        pre_q <= 9'h000;
      end else begin
        pre_q <= pre_q + 9'h001;
      end
    end
  end
  assign tick10 = osc_tick && (remove_q == 8'h00) && (pre_q == 9'(TICKS_10MS - 1));
  assign tick_10ms_o = tick10;

  // Sync low-time measurement in a single valid mode
  assign sync_on = is_one_hot({1'b0, stat2_q[S2_SYNC_MIN:S2_SYNC_LO]});
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      slow_q <= 16'h0000;
    end else if (!sync_on || sy_q) begin
      slow_q <= 16'h0000;
    end else if (slow_q != 16'(SYNC_CYC)) begin
      slow_q <= slow_q + 16'h0001;
    end
  end
  assign align = sync_on && !sy_q && (slow_q == 16'(SYNC_CYC - 1));

  // Time counters with alignment to second or minute
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      hund_q <= 7'h00;
      sec_q <= 6'h00;
      min_q <= 6'h00;
    end else if (align && stat2_q[S2_SYNC_SEC]) begin
      hund_q <= 7'h00;
      if (hund_q > 7'(HUND_ROUND)) begin
        sec_q <= (sec_q == 6'(SEC_MAX)) ? 6'h00 : sec_q + 6'h01;
      end
    end else if (align && stat2_q[S2_SYNC_MIN]) begin
      hund_q <= 7'h00;
      sec_q <= 6'h00;
      if (sec_q > 6'(SEC_ROUND)) begin
        min_q <= (min_q == 6'(SEC_MAX)) ? 6'h00 : min_q + 6'h01;
      end
    end else if (tick10) begin
      hund_q <= (hund_q == 7'(HUND_MAX)) ? 7'h00 : hund_q + 7'h01;
      if (tick_sec) begin
        sec_q <= (sec_q == 6'(SEC_MAX)) ? 6'h00 : sec_q + 6'h01;
        if (tick_min) begin
          min_q <= (min_q == 6'(SEC_MAX)) ? 6'h00 : min_q + 6'h01;
        end
      end
    end
  end

  // Interval events and the selected pulse
  assign tick_100 = tick10 && (7'(hund_q % 7'd10) == 7'(TENTH_LAST));
  assign tick_sec = tick10 && (hund_q == 7'(HUND_MAX));
  assign tick_min = tick_sec && (sec_q == 6'(SEC_MAX));
  assign pulse_evt = pulse_ok && is_one_hot(stat2_q[S2_PSEL_LO+3:S2_PSEL_LO]) &&
    ((stat2_q[S2_PSEL_LO] && tick10) || (stat2_q[S2_PSEL_LO+1] && tick_100) ||
     (stat2_q[S2_PSEL_LO+2] && tick_sec) || (stat2_q[S2_PSEL_LO+3] && tick_min));

  // Tuning output armed by writing zero to trim while tuning
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      freq_out_q <= 1'b0;
    end else if (!stat0_q[S0_TUNE]) begin
      freq_out_q <= 1'b0;
    end else if (wr_fire && idx == IDX_TRIM && !stat0_q[S0_LOCK]) begin
      freq_out_q <= (wd == 8'h00);
    end
  end

  // Interrupt request selection
  assign any_unmasked = |(stat1_q[S1_TIMER_FLAG:S1_PULSE_FLAG] &
                          stat1_q[S1_TIMER_MASK:S1_PULSE_MASK]);
  assign stby_irq = stat1_q[S1_ALARM_FLAG] & stat1_q[S1_ALARM_MASK];
  always_comb begin
    if (pf_q) begin
      irq_d = stby_irq;
    end else if (freq_out_q) begin
      irq_d = (pre_q < 9'(DUTY_TICKS));
    end else begin
      irq_d = any_unmasked;
    end
  end

  // Registered open-drain enable
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= irq_d;
    end
  end
  assign irq_n_o = 1'b0;
  assign irq_n_oe = irq_q;

  // Controls for the clock logic; reads and user RAM never see the lock
  assign alarm_en_o = stat0_q[S0_ALARM_EN];
  assign timer_en_o = stat0_q[S0_TIMER_EN];
  assign xfer_write_en_o = !stat0_q[S0_LOCK];

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  // Checks next to the logic
  AST_IRQ_OR: assert property (!pf_q && !freq_out_q && any_unmasked |=> irq_n_oe)
    else $error("unmasked flag did not pull interrupt");
  AST_STBY_ALARM: assert property (pf_q && stby_irq |=> irq_n_oe)
    else $error("standby alarm did not pull interrupt");
  AST_STBY_BLOCK: assert property (pf_q && !stby_irq |=> !irq_n_oe)
    else $error("interrupt active in standby without alarm");
  AST_FLAG_STICKY: assert property (stat1_q[S1_TIMER_FLAG] && !(wr_fire && idx == IDX_STAT1)
    && !init_fall |=> stat1_q[S1_TIMER_FLAG])
    else $error("timer flag dropped without software");
  AST_PULSE_STBY: assert property (pf_q |-> !pulse_evt)
    else $error("pulse fired in standby");
  AST_PULSE_SEL: assert property (pulse_evt |-> is_one_hot(stat2_q[3:0]) && stat0_q[S0_PULSE_EN])
    else $error("pulse fired with bad selection");
  AST_LOCK_TRIM: assert property (wr_fire && idx == IDX_TRIM && stat0_q[S0_LOCK]
    |=> $stable(trim_q))
    else $error("trim written while locked");
  AST_INIT: assert property (init_fall |=> stat0_q == STAT0_INIT && stat1_q[2:0] == 3'h0)
    else $error("init did not enter tuning mode");
  AST_SYNC_SEC: assert property (align && stat2_q[S2_SYNC_SEC] && hund_q > 7'(HUND_ROUND)
    && sec_q < 6'(SEC_MAX) |=> hund_q == 7'h00 && sec_q == $past(sec_q) + 6'h01)
    else $error("second alignment wrong");
  AST_SYNC_MIN: assert property (align && stat2_q[S2_SYNC_MIN] && sec_q <= 6'(SEC_ROUND)
    |=> sec_q == 6'h00 && $stable(min_q))
    else $error("minute alignment wrong");
  AST_TRIM_ZERO: assert property (osc_tick && tper_q == 20'(TRIM_PERIOD - 1) && trim_q == 8'h00
    |=> remove_q == 8'h00)
    else $error("trim zero removed pulses");

endmodule : rit_irq_sync_pulse_trim

// file: test/rit_host_model.sv
// Host model: Avalon-MM master tasks and the pulled-up interrupt line.
// Assumes the block answers every request by dropping waitrequest.
`timescale 1ns/1ps
module rit_host_model (
  // Clock
  input wire logic sys_clk,
  // Avalon-MM master
  output logic [6:0] avs_address,
  output logic avs_read,
  output logic avs_write,
  output logic [31:0] avs_writedata,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  // Interrupt pin and status
  input wire logic irq_n_o,
  input wire logic irq_n_oe,
  output logic irq_line,
  output logic timeout
);
  // External pull-up: a released line reads high
  assign irq_line = irq_n_oe ? irq_n_o : 1'b1;

  // Idle bus at time zero
  initial begin
    avs_address = 7'h00;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h00000000;
    timeout = 1'b0;
  end

  // One bus cycle; request held until waitrequest is seen low
  task automatic xfer(input logic w, input logic [4:0] idx, input logic [7:0] d,
                      output logic [7:0] q);
    int n;
    avs_address <= {idx, 2'b00};
    avs_read <= ~w;
    avs_write <= w;
    avs_writedata <= {24'h000000, d};
    n = 0;
    do begin
      @(posedge sys_clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 64);
    if (n >= 64) timeout = 1'b1;
    q = avs_readdata[7:0];
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    @(posedge sys_clk);
  endtask : xfer

  // Acknowledge: wait 60 us after the interrupt, then rewrite status 1
  task automatic ack_irq(input logic [7:0] s1);
    logic [7:0] q;
    repeat (15000) @(posedge sys_clk);
    xfer(1'b1, 5'h01, s1, q);
  endtask : ack_irq
endmodule : rit_host_model

// file: test/rit_irq_sync_pulse_trim_tb.sv
// Bench for the interrupt, sync, pulse and trim block.
// Assumes OSC_DIV of 4, so one 10 ms period lasts 1308 clock cycles.
`timescale 1ns/1ps
module rit_irq_sync_pulse_trim_tb;
  import rit_pkg::*;
  localparam int DIV = 4;
  localparam int P10 = TICKS_10MS * DIV;
  logic sys_clk, rst, power_fail_in, sync_n_in, alarm_match_in, timer_rollover_in;
  logic [6:0] avs_address;
  logic avs_read, avs_write, avs_waitrequest, irq_n_o, irq_n_oe, irq_line, timeout;
  logic [31:0] avs_writedata, avs_readdata;
  logic alarm_en_o, timer_en_o, xfer_write_en_o, tick_10ms_o;
  logic [7:0] q;
  int fails = 0;
  int n_compared = 0;

  // Clock
  initial begin
    sys_clk = 1'b0;
    forever #2 sys_clk = ~sys_clk;
  end

  rit_irq_sync_pulse_trim #(.OSC_DIV(DIV), .SYNC_CYC(20)) uut (
    .sys_clk(sys_clk), .rst(rst), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .power_fail_in(power_fail_in),
    .sync_n_in(sync_n_in), .irq_n_o(irq_n_o), .irq_n_oe(irq_n_oe),
    .alarm_match_in(alarm_match_in), .timer_rollover_in(timer_rollover_in),
    .alarm_en_o(alarm_en_o), .timer_en_o(timer_en_o),
    .xfer_write_en_o(xfer_write_en_o), .tick_10ms_o(tick_10ms_o)
  );

  rit_host_model host (
    .sys_clk(sys_clk), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .irq_n_o(irq_n_o), .irq_n_oe(irq_n_oe),
    .irq_line(irq_line), .timeout(timeout)
  );

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      fails++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk);
  endtask : cyc

  task automatic wr(input logic [4:0] idx, input logic [7:0] d);
    host.xfer(1'b1, idx, d, q);
  endtask : wr

  task automatic rd(input logic [4:0] idx, input logic [7:0] e, input string nm);
    host.xfer(1'b0, idx, 8'h00, q);
    chk(nm, {24'h0, e}, {24'h0, q});
  endtask : rd

  task automatic wait_oe(input logic v, input int lim);
    int n;
    n = 0;
    while (irq_n_oe !== v && n < lim) begin
      @(posedge sys_clk);
      n++;
    end
  endtask : wait_oe

  // Reset values, unmapped place, pin idle levels
  task automatic t_reset;
    wr(5'h05, 8'haa);
    rd(5'h05, 8'h00, "unmapped");
    rd(IDX_STAT0, STAT0_RST, "stat0");
    rd(IDX_STAT1, STAT1_RST, "stat1");
    rd(IDX_STAT2, STAT2_RST, "stat2");
    rd(IDX_TRIM, TRIM_RST, "trim");
    chk("irq_line", 1, irq_line);
    chk("xfer_en", 1, xfer_write_en_o);
  endtask : t_reset

  // Periodic pulse: flag, interrupt, acknowledge, double select
  task automatic t_pulse;
    wr(IDX_STAT0, 8'h02);
    wr(IDX_STAT1, 8'h01);
    wr(IDX_STAT2, 8'h01);
    wait_oe(1'b1, P10 * 2);
    chk("irq_line", 0, irq_line);
    rd(IDX_STAT1, 8'h11, "stat1");
    wr(IDX_STAT2, 8'h03);
    host.ack_irq(8'h01);
    cyc(1);
    chk("irq_oe", 0, irq_n_oe);
    cyc(P10 * 2);
    rd(IDX_STAT1, 8'h01, "stat1");
  endtask : t_pulse

  // Standby: only alarm may interrupt; pulse suspended then resumed
  task automatic t_standby;
    power_fail_in <= 1'b1;
    cyc(8);
    wr(IDX_STAT0, 8'h0e);
    wr(IDX_STAT1, 8'h07);
    wr(IDX_STAT2, 8'h01);
    chk("timer_en", 1, timer_en_o);
    timer_rollover_in <= 1'b1;
    cyc(1);
    timer_rollover_in <= 1'b0;
    cyc(P10 * 2);
    chk("irq_oe", 0, irq_n_oe);
    rd(IDX_STAT1, 8'h47, "stat1");
    alarm_match_in <= 1'b1;
    cyc(1);
    alarm_match_in <= 1'b0;
    cyc(4);
    chk("irq_line", 0, irq_line);
    power_fail_in <= 1'b0;
    host.ack_irq(8'h07);
    cyc(1);
    wait_oe(1'b1, P10 * 2);
    rd(IDX_STAT1, 8'h17, "stat1");
  endtask : t_standby

  // Lock blocks trim writes; init clears lock and enters tuning
  task automatic t_lock_init;
    wr(IDX_STAT0, 8'h20);
    cyc(2);
    chk("xfer_en", 0, xfer_write_en_o);
    wr(IDX_TRIM, 8'h55);
    rd(IDX_TRIM, 8'h00, "trim");
    wr(IDX_STAT2, 8'h10);
    wr(IDX_STAT2, 8'h00);
    rd(IDX_STAT0, STAT0_INIT, "stat0");
    rd(IDX_STAT1, 8'h00, "stat1");
    chk("xfer_en", 1, xfer_write_en_o);
    wr(IDX_TRIM, 8'hff);
    rd(IDX_TRIM, 8'hff, "trim");
  endtask : t_lock_init

  // Tuning output: 20 percent high time, ends when tuning bit cleared
  task automatic t_tune;
    int n;
    wr(IDX_TRIM, 8'h00);
    wait_oe(1'b1, P10 * 2);
    // Skip a possibly partial first high phase
    wait_oe(1'b0, P10 * 2);
    wait_oe(1'b1, P10 * 2);
    n = 0;
    while (irq_n_oe === 1'b1 && n < 2000) begin
      @(posedge sys_clk);
      n++;
    end
    chk("tune_high", DUTY_TICKS * DIV, n);
    wr(IDX_STAT0, 8'h00);
    cyc(P10 * 2);
    chk("irq_oe", 0, irq_n_oe);
  endtask : t_tune

  // 50 Hz sync: a long low on the pin restarts the 10 ms divider
  task automatic t_sync;
    int n;
    wr(IDX_STAT2, 8'h20);
    while (tick_10ms_o !== 1'b1) @(posedge sys_clk);
    sync_n_in <= 1'b0;
    n = 0;
    do begin
      @(posedge sys_clk);
      n++;
    end while (tick_10ms_o !== 1'b1 && n < 4000);
    sync_n_in <= 1'b1;
    chk("sync_align", 1, (n >= 20 + P10 - DIV) && (n <= 24 + P10));
  endtask : t_sync

  task automatic give_verdict;
    if (timeout === 1'b1) fails++;
    if (fails == 0 && n_compared > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : give_verdict

  // Main sequence
  initial begin
    rst = 1'b1;
    power_fail_in = 1'b0;
    sync_n_in = 1'b1;
    alarm_match_in = 1'b0;
    timer_rollover_in = 1'b0;
    cyc(2);
    rst <= 1'b0;
    cyc(1);
    t_reset();
    t_pulse();
    t_standby();
    t_lock_init();
    t_tune();
    t_sync();
    give_verdict();
  end

  // Watchdog
  initial begin
    cyc(100000);
    fails++;
    give_verdict();
  end
endmodule : rit_irq_sync_pulse_trim_tb
